// ==== hdl/sdc_cfg.svh ====
// constants for the segment descriptor cache and system register block
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// ------------------------------------------------------------
// segment slots and cache reset contents
// ------------------------------------------------------------
`define SDC_SEG_CNT 6
`define SDC_SEG_CODE 3'h0
`define SDC_SEG_STACK 3'h1
`define SDC_SEG_DATA 3'h2
`define SDC_SEG_EXTRA 3'h3
`define SDC_SEG_FOURTH 3'h4
`define SDC_SEG_FIFTH 3'h5
`define SDC_REAL_LIMIT 32'h0000FFFF
`define SDC_REAL_ATTR 8'h93
`define SDC_RST_BASE 32'h00000000
`define SDC_RST_SEL 16'h0000

// ------------------------------------------------------------
// attribute byte fields
// ------------------------------------------------------------
`define SDC_ATTR_PRESENT 7
`define SDC_ATTR_CODE 3
`define SDC_ATTR_RW 1

// ------------------------------------------------------------
// system register index map
// ------------------------------------------------------------
`define SDC_SYS_MCR 4'h0
`define SDC_SYS_RSVD 4'h1
`define SDC_SYS_FAULT_ADDR 4'h2
`define SDC_SYS_PAGE_BASE 4'h3
`define SDC_SYS_GTB_BASE 4'h4
`define SDC_SYS_GTB_LIMIT 4'h5
`define SDC_SYS_ITB_BASE 4'h6
`define SDC_SYS_ITB_LIMIT 4'h7
`define SDC_SYS_LOCAL_SEL 4'h8
`define SDC_SYS_TASK_SEL 4'h9

// ------------------------------------------------------------
// machine control register bits, mask and reset value
// ------------------------------------------------------------
`define SDC_MCR_PG 31
`define SDC_MCR_CE 30
`define SDC_MCR_WT 29
`define SDC_MCR_PE 0
`define SDC_MCR_MASK 32'hE005002F
`define SDC_MCR_RST 32'h00000000
`define SDC_GP_CODE_ZERO 16'h0000
`define SDC_PRIV_TOP 2'h0

`endif

// ==== hdl/sdc_pkg.sv ====
// types shared by the segment descriptor cache block
package sdc_pkg;

  // operating mode decoded from paging and protection enables
  typedef enum logic [1:0] {
    SDC_MODE_REAL = 2'b00,
    SDC_MODE_PROT = 2'b01,
    SDC_MODE_UNDEF = 2'b10,
    SDC_MODE_PAGED = 2'b11
  } sdc_mode_t;

  // kind of memory reference
  typedef enum logic [1:0] {
    SDC_ACC_READ = 2'b00,
    SDC_ACC_WRITE = 2'b01,
    SDC_ACC_EXEC = 2'b10,
    SDC_ACC_NONE = 2'b11
  } sdc_acc_t;

endpackage

// ==== hdl/sdc_seg_check.sv ====
// per-reference linear address, limit check and attribute check
`timescale 1ns/1ps
`default_nettype none
`include "sdc_cfg.svh"

module sdc_seg_check (
  // cached descriptor of the segment in use
  input wire logic [31:0] base,
  input wire logic [31:0] limit,
  input wire logic [7:0] attr,
  // reference
  input wire logic [31:0] offset,
  input wire logic [1:0] size_m1,
  input wire sdc_pkg::sdc_acc_t acc,
  // results
  output logic [31:0] lin_addr,
  output logic limit_bad,
  output logic attr_bad
);

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  wire logic [32:0] last_byte;
  wire logic present;
  wire logic is_code;
  wire logic rw_ok;

  // base is a plain addend; carry out wraps like the real adder
  assign lin_addr = base + offset;
  // last byte of a multi-byte access must also sit inside the limit
  assign last_byte = {1'b0, offset} + {31'h0, size_m1};
  assign limit_bad = last_byte > {1'b0, limit};
  assign present = attr[`SDC_ATTR_PRESENT];
  assign is_code = attr[`SDC_ATTR_CODE];
  assign rw_ok = attr[`SDC_ATTR_RW];
  // code is never written, data never executed, code read needs rw
  assign attr_bad = !present
    || (acc == sdc_pkg::SDC_ACC_WRITE && (is_code || !rw_ok))
    || (acc == sdc_pkg::SDC_ACC_EXEC && !is_code)
    || (acc == sdc_pkg::SDC_ACC_READ && is_code && !rw_ok);

endmodule
`default_nettype wire

// ==== hdl/sdc_core.sv ====
// segment selector and descriptor cache with system-level registers
`timescale 1ns/1ps
`default_nettype none
`include "sdc_cfg.svh"

module sdc_core (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // selector load with the descriptor the selector indexes
  input wire logic sel_load,
  input wire logic [2:0] sel_idx,
  input wire logic [15:0] sel_value,
  input wire logic [31:0] desc_base,
  input wire logic [31:0] desc_limit,
  input wire logic [7:0] desc_attr,
  // memory reference
  input wire logic ref_valid,
  input wire logic [2:0] ref_seg,
  input wire logic [31:0] ref_offset,
  input wire logic [1:0] ref_size_m1,
  input wire sdc_pkg::sdc_acc_t ref_acc,
  output logic lin_valid_ff,
  output logic [31:0] lin_addr_ff,
  output logic ref_fault_ff,
  // system register access
  input wire logic sys_wr,
  input wire logic sys_rd,
  input wire logic [3:0] sys_idx,
  input wire logic [31:0] sys_wdata,
  input wire logic [1:0] cpl,
  output logic sys_ack_ff,
  output logic [31:0] sys_rdata_ff,
  output logic gp_fault_ff,
  output logic [15:0] gp_code_ff,
  // state seen by the rest of the core
  output sdc_pkg::sdc_mode_t mode,
  output logic [31:0] mcr_ff,
  output logic [31:0] page_base_ff
);

  // ------------------------------------------------------------
  // segment caches, one slot per selector register
  // ------------------------------------------------------------
  logic [15:0] sel_ff [`SDC_SEG_CNT];
  logic [31:0] base_ff [`SDC_SEG_CNT];
  logic [31:0] limit_ff [`SDC_SEG_CNT];
  logic [7:0] attr_ff [`SDC_SEG_CNT];
  wire logic real_mode;
  wire logic [31:0] real_base;

  // mode is pure decode of the two enables, never stored separately
  assign mode = sdc_pkg::sdc_mode_t'({mcr_ff[`SDC_MCR_PG],
                                      mcr_ff[`SDC_MCR_PE]});
  assign real_mode = !mcr_ff[`SDC_MCR_PE];
  assign real_base = {12'h000, sel_value, 4'h0};

  // each slot reloads on its own load strobe; in real mode the limit
  // and attributes keep whatever they held, as software expects
  genvar g;
  generate
    for (g = 0; g < `SDC_SEG_CNT; g++) begin : g_seg
      wire logic hit;
      wire logic [31:0] nxt_base;
      wire logic [31:0] nxt_limit;
      wire logic [7:0] nxt_attr;
      assign hit = sel_load && (sel_idx == 3'(g));
      assign nxt_base = real_mode ? real_base : desc_base;
      assign nxt_limit = real_mode ? limit_ff[g] : desc_limit;
      assign nxt_attr = real_mode ? attr_ff[g] : desc_attr;
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sel_ff[g] <= `SDC_RST_SEL;
          base_ff[g] <= `SDC_RST_BASE;
          limit_ff[g] <= `SDC_REAL_LIMIT;
          attr_ff[g] <= `SDC_REAL_ATTR;
        end else if (hit) begin
          sel_ff[g] <= sel_value;
          base_ff[g] <= nxt_base;
          limit_ff[g] <= nxt_limit;
          attr_ff[g] <= nxt_attr;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // memory reference path
  // ------------------------------------------------------------
  wire logic seg_ok;
  wire logic [2:0] seg_i;
  wire logic [31:0] chk_lin;
  wire logic chk_limit_bad;
  wire logic chk_attr_bad;
  wire logic ref_bad;

  // an unknown segment index faults rather than aliasing slot zero
  assign seg_ok = ref_seg < 3'(`SDC_SEG_CNT);
  assign seg_i = seg_ok ? ref_seg : 3'h0;

  sdc_seg_check u_check (
    .base(base_ff[seg_i]),
    .limit(limit_ff[seg_i]),
    .attr(attr_ff[seg_i]),
    .offset(ref_offset),
    .size_m1(ref_size_m1),
    .acc(ref_acc),
    .lin_addr(chk_lin),
    .limit_bad(chk_limit_bad),
    .attr_bad(chk_attr_bad)
  );

  assign ref_bad = !seg_ok || chk_limit_bad || chk_attr_bad;

  // a failing reference never reaches memory
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lin_valid_ff <= 1'b0;
      lin_addr_ff <= 32'h00000000;
      ref_fault_ff <= 1'b0;
    end else begin
      lin_valid_ff <= ref_valid && !ref_bad;
      ref_fault_ff <= ref_valid && ref_bad;
      if (ref_valid && !ref_bad) begin
        lin_addr_ff <= chk_lin;
      end
    end
  end

  // ------------------------------------------------------------
  // system-level registers
  // ------------------------------------------------------------
  logic [31:0] fault_addr_ff;
  logic [31:0] gtb_base_ff;
  logic [15:0] gtb_limit_ff;
  logic [31:0] itb_base_ff;
  logic [15:0] itb_limit_ff;
  logic [15:0] local_sel_ff;
  logic [15:0] task_sel_ff;
  wire logic sys_req;
  wire logic priv_ok;
  wire logic idx_bad;
  wire logic mcr_bad;
  wire logic sys_bad;
  wire logic wr_ok;
  wire logic [31:0] rd_mux;

  assign sys_req = sys_wr || sys_rd;
  assign priv_ok = cpl == `SDC_PRIV_TOP;
  // the reserved slot and anything above the map fault like a bad index
  assign idx_bad = sys_idx == `SDC_SYS_RSVD
    || sys_idx > `SDC_SYS_TASK_SEL;
  // paging without protection, or fills on with write-through off
  assign mcr_bad = sys_wr && sys_idx == `SDC_SYS_MCR
    && ((sys_wdata[`SDC_MCR_PG] && !sys_wdata[`SDC_MCR_PE])
    || (sys_wdata[`SDC_MCR_CE] && !sys_wdata[`SDC_MCR_WT]));
  assign sys_bad = !priv_ok || idx_bad || mcr_bad;
  assign wr_ok = sys_wr && !sys_bad;

  // read selection; narrow registers read with zeros above
  assign rd_mux =
    sys_idx == `SDC_SYS_MCR ? mcr_ff :
    sys_idx == `SDC_SYS_FAULT_ADDR ? fault_addr_ff :
    sys_idx == `SDC_SYS_PAGE_BASE ? page_base_ff :
    sys_idx == `SDC_SYS_GTB_BASE ? gtb_base_ff :
    sys_idx == `SDC_SYS_GTB_LIMIT ? {16'h0000, gtb_limit_ff} :
    sys_idx == `SDC_SYS_ITB_BASE ? itb_base_ff :
    sys_idx == `SDC_SYS_ITB_LIMIT ? {16'h0000, itb_limit_ff} :
    sys_idx == `SDC_SYS_LOCAL_SEL ? {16'h0000, local_sel_ff} :
    sys_idx == `SDC_SYS_TASK_SEL ? {16'h0000, task_sel_ff} :
    32'h00000000;

  // writes; only the ten defined control bits are kept
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mcr_ff <= `SDC_MCR_RST;
      fault_addr_ff <= 32'h00000000;
      page_base_ff <= 32'h00000000;
      gtb_base_ff <= 32'h00000000;
      gtb_limit_ff <= 16'hFFFF;
      itb_base_ff <= 32'h00000000;
      itb_limit_ff <= 16'hFFFF;
      local_sel_ff <= 16'h0000;
      task_sel_ff <= 16'h0000;
    end else if (wr_ok) begin
      case (sys_idx)
        `SDC_SYS_MCR: mcr_ff <= sys_wdata & `SDC_MCR_MASK;
        `SDC_SYS_FAULT_ADDR: fault_addr_ff <= sys_wdata;
        `SDC_SYS_PAGE_BASE: page_base_ff <= sys_wdata;
        `SDC_SYS_GTB_BASE: gtb_base_ff <= sys_wdata;
        `SDC_SYS_GTB_LIMIT: gtb_limit_ff <= sys_wdata[15:0];
        `SDC_SYS_ITB_BASE: itb_base_ff <= sys_wdata;
        `SDC_SYS_ITB_LIMIT: itb_limit_ff <= sys_wdata[15:0];
        `SDC_SYS_LOCAL_SEL: local_sel_ff <= sys_wdata[15:0];
        `SDC_SYS_TASK_SEL: task_sel_ff <= sys_wdata[15:0];
        default: mcr_ff <= mcr_ff;
      endcase
    end
  end

  // answer: ack on success, general protection fault otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_ack_ff <= 1'b0;
      sys_rdata_ff <= 32'h00000000;
      gp_fault_ff <= 1'b0;
      gp_code_ff <= `SDC_GP_CODE_ZERO;
    end else begin
      sys_ack_ff <= sys_req && !sys_bad;
      gp_fault_ff <= sys_req && sys_bad;
      gp_code_ff <= `SDC_GP_CODE_ZERO;
      if (sys_rd && !sys_bad) begin
        sys_rdata_ff <= rd_mux;
      end
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sel_refresh: assert property (
    sel_load && sel_idx < 3'(`SDC_SEG_CNT)
    |=> sel_ff[$past(sel_idx)] == $past(sel_value))
    else $error("selector not stored on load");
  a_real_base_shift: assert property (
    sel_load && real_mode && sel_idx < 3'(`SDC_SEG_CNT)
    |=> base_ff[$past(sel_idx)] == {12'h000, $past(sel_value), 4'h0})
    else $error("real mode base not selector shifted by four");
  a_real_limit_fixed: assert property (
    sel_load && real_mode && sel_idx < 3'(`SDC_SEG_CNT)
    |=> limit_ff[$past(sel_idx)] == $past(limit_ff[sel_idx])
        && attr_ff[$past(sel_idx)] == $past(attr_ff[sel_idx]))
    else $error("real mode load changed limit or attributes");
  a_prot_fill: assert property (
    sel_load && !real_mode && sel_idx < 3'(`SDC_SEG_CNT)
    |=> base_ff[$past(sel_idx)] == $past(desc_base)
        && limit_ff[$past(sel_idx)] == $past(desc_limit)
        && attr_ff[$past(sel_idx)] == $past(desc_attr))
    else $error("protected load did not copy descriptor");
  a_lin_addr_sum: assert property (
    ref_valid && ref_seg < 3'(`SDC_SEG_CNT) && !sel_load && !ref_bad
    |=> lin_valid_ff
        && lin_addr_ff == base_ff[$past(ref_seg)] + $past(ref_offset))
    else $error("linear address not base plus offset");
  a_limit_fault: assert property (
    ref_valid && ref_seg < 3'(`SDC_SEG_CNT)
    && ref_offset > limit_ff[ref_seg]
    |=> ref_fault_ff && !lin_valid_ff)
    else $error("reference past limit not faulted");
  a_attr_write_code: assert property (
    ref_valid && ref_seg < 3'(`SDC_SEG_CNT)
    && ref_acc == sdc_pkg::SDC_ACC_WRITE
    && attr_ff[ref_seg][`SDC_ATTR_CODE]
    |=> ref_fault_ff ##0 !lin_valid_ff)
    else $error("write to code segment not faulted");
  a_priv_block: assert property (
    sys_wr && cpl != `SDC_PRIV_TOP
    |=> gp_fault_ff && !sys_ack_ff && $stable(mcr_ff))
    else $error("system write allowed above privilege zero");
  a_rsvd_slot: assert property (
    sys_req && sys_idx == `SDC_SYS_RSVD |=> gp_fault_ff)
    else $error("reserved control slot accepted");
  a_mcr_mask: assert property (
    (mcr_ff & ~`SDC_MCR_MASK) == 32'h00000000)
    else $error("undefined control bit set");
  a_mode_map: assert property (
    mode != sdc_pkg::SDC_MODE_UNDEF
    && (mode == sdc_pkg::SDC_MODE_REAL) == real_mode)
    else $error("mode does not follow enables");
  a_pg_no_pe: assert property (
    sys_wr && cpl == `SDC_PRIV_TOP && sys_idx == `SDC_SYS_MCR
    && sys_wdata[`SDC_MCR_PG] && !sys_wdata[`SDC_MCR_PE]
    |=> gp_fault_ff && gp_code_ff == `SDC_GP_CODE_ZERO
    ##1 mode != sdc_pkg::SDC_MODE_UNDEF)
    else $error("paging without protection not faulted");

  a_ref_exclusive: assert property (
    !(lin_valid_ff && ref_fault_ff))
    else $error("reference both passed and faulted");

  // main scenarios reached
  c_real_load: cover property (sel_load && real_mode);
  c_prot_load: cover property (sel_load && !real_mode);
  c_ref_fault: cover property (ref_fault_ff);
  c_gp_fault: cover property (gp_fault_ff);
  c_paged_mode: cover property (mode == sdc_pkg::SDC_MODE_PAGED);

endmodule
`default_nettype wire

// ==== tb/sdc_desc_model.sv ====
// descriptor table model standing in for the core's table walk
`timescale 1ns/1ps
`default_nettype none

module sdc_desc_model (
  // selector presented with a load
  input wire logic [15:0] sel_value,
  // descriptor the selector indexes
  output logic [31:0] desc_base,
  output logic [31:0] desc_limit,
  output logic [7:0] desc_attr
);
  // small fixed table; unknown selectors give an absent null descriptor
  // so that a stray load can never look like a good segment
  always_comb begin
    case (sel_value)
      16'h0008: {desc_base, desc_limit, desc_attr} =
        {32'h00100000, 32'h00000FFF, 8'h93};
      16'h0010: {desc_base, desc_limit, desc_attr} =
        {32'h00200000, 32'h0000FFFF, 8'h9A};
      16'h0018: {desc_base, desc_limit, desc_attr} =
        {32'h00300000, 32'h0000FFFF, 8'h13};
      default: {desc_base, desc_limit, desc_attr} =
        {32'hFFFFFFFF, 32'h00000000, 8'h00};
    endcase
  end
endmodule

`default_nettype wire

// ==== tb/segment_descriptor_cache_tb.sv ====
// self-checking bench for the segment descriptor cache core
`timescale 1ns/1ps
`default_nettype none
`include "sdc_cfg.svh"

module segment_descriptor_cache_tb;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0, rst = 1'b1;
  logic sel_load = 1'b0, ref_valid = 1'b0, sys_wr = 1'b0, sys_rd = 1'b0;
  logic [2:0] sel_idx = 3'h0, ref_seg = 3'h0;
  logic [3:0] sys_idx = 4'h0;
  logic [15:0] sel_value = 16'h0000;
  logic [31:0] desc_base, desc_limit, ref_offset = 32'h0, sys_wdata = 32'h0;
  logic [7:0] desc_attr;
  logic [1:0] ref_size_m1 = 2'h0, cpl = 2'h0;
  sdc_pkg::sdc_acc_t ref_acc = sdc_pkg::SDC_ACC_READ;
  logic lin_valid_ff, ref_fault_ff, sys_ack_ff, gp_fault_ff;
  logic [31:0] lin_addr_ff, sys_rdata_ff, mcr_ff, page_base_ff;
  logic [15:0] gp_code_ff;
  sdc_pkg::sdc_mode_t mode;
  int mismatches = 0, n_checks = 0, cyc = 0;

  always #10 clk = ~clk;

  sdc_desc_model i_sdc_desc_model (.sel_value(sel_value),
    .desc_base(desc_base), .desc_limit(desc_limit), .desc_attr(desc_attr));

  sdc_core i_sdc_core (.clk(clk), .rst(rst), .sel_load(sel_load),
    .sel_idx(sel_idx), .sel_value(sel_value), .desc_base(desc_base),
    .desc_limit(desc_limit), .desc_attr(desc_attr), .ref_valid(ref_valid),
    .ref_seg(ref_seg), .ref_offset(ref_offset), .ref_size_m1(ref_size_m1),
    .ref_acc(ref_acc), .lin_valid_ff(lin_valid_ff), .lin_addr_ff(lin_addr_ff),
    .ref_fault_ff(ref_fault_ff), .sys_wr(sys_wr), .sys_rd(sys_rd),
    .sys_idx(sys_idx), .sys_wdata(sys_wdata), .cpl(cpl),
    .sys_ack_ff(sys_ack_ff), .sys_rdata_ff(sys_rdata_ff),
    .gp_fault_ff(gp_fault_ff), .gp_code_ff(gp_code_ff), .mode(mode),
    .mcr_ff(mcr_ff), .page_base_ff(page_base_ff));

  // ------------------------------------------------------------
  // verdict, compares and timeout
  // ------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk_bit(input logic a, input logic e, input string m);
    n_checks++;
    if (a !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %b want %b", $time, m, a, e);
    end
  endtask

  task automatic chk_word(input logic [31:0] a, input logic [31:0] e,
                          input string m);
    n_checks++;
    if (a !== e) begin
      mismatches++;
      $display("Error at %0t: %s got %h want %h", $time, m, a, e);
    end
  endtask

  task automatic chk_mode(input sdc_pkg::sdc_mode_t a,
                          input sdc_pkg::sdc_mode_t e);
    n_checks++;
    if (a !== e) begin
      mismatches++;
      $display("Error at %0t: mode got %b want %b", $time, a, e);
    end
  endtask

  // a hung run costs a mismatch; tests need under a hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      mismatches++;
      results();
    end
  end

  // ------------------------------------------------------------
  // one-cycle request tasks, driven on the falling edge
  // ------------------------------------------------------------
  task automatic ld(input logic [2:0] idx, input logic [15:0] sel);
    sel_load = 1'b1;
    sel_idx = idx;
    sel_value = sel;
    @(negedge clk);
    sel_load = 1'b0;
    // one idle cycle keeps back-to-back strobes from retoggling in a step
    @(negedge clk);
  endtask

  // answer flags stand for the single cycle after the request edge
  task automatic mref(input logic [2:0] seg, input logic [31:0] off,
                      input logic [1:0] sz, input sdc_pkg::sdc_acc_t acc,
                      input logic ok, input logic [31:0] addr);
    ref_valid = 1'b1;
    ref_seg = seg;
    ref_offset = off;
    ref_size_m1 = sz;
    ref_acc = acc;
    @(negedge clk);
    ref_valid = 1'b0;
    chk_bit(lin_valid_ff, ok, "lin_valid");
    chk_bit(ref_fault_ff, !ok, "ref_fault");
    if (ok) chk_word(lin_addr_ff, addr, "lin_addr");
    @(negedge clk);
  endtask

  task automatic sys(input logic wr, input logic [3:0] idx,
                     input logic [31:0] d, input logic [1:0] pl,
                     input logic ok, input logic [31:0] rd);
    sys_wr = wr;
    sys_rd = !wr;
    sys_idx = idx;
    sys_wdata = d;
    cpl = pl;
    @(negedge clk);
    sys_wr = 1'b0;
    sys_rd = 1'b0;
    chk_bit(sys_ack_ff, ok, "sys_ack");
    chk_bit(gp_fault_ff, !ok, "gp_fault");
    if (!ok) chk_word({16'h0, gp_code_ff}, 32'h0, "gp_code");
    if (ok && !wr) chk_word(sys_rdata_ff, rd, "sys_rdata");
    @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_real();
    chk_mode(mode, sdc_pkg::SDC_MODE_REAL);
    mref(`SDC_SEG_CODE, 32'h0000FFFF, 2'h0, sdc_pkg::SDC_ACC_READ, 1'b1,
         32'h0000FFFF);
    mref(`SDC_SEG_CODE, 32'h0000FFFF, 2'h1, sdc_pkg::SDC_ACC_READ, 1'b0,
         32'h0);
    ld(`SDC_SEG_DATA, 16'h1234);
    mref(`SDC_SEG_DATA, 32'h00000010, 2'h0, sdc_pkg::SDC_ACC_WRITE, 1'b1,
         32'h00012350);
    mref(`SDC_SEG_DATA, 32'h0000FFFE, 2'h1, sdc_pkg::SDC_ACC_WRITE, 1'b1,
         32'h0002233E);
    mref(3'h6, 32'h0, 2'h0, sdc_pkg::SDC_ACC_READ, 1'b0, 32'h0);
  endtask

  task automatic t_sys_regs();
    sys(1'b1, `SDC_SYS_MCR, 32'h00000001, 2'h3, 1'b0, 32'h0);
    chk_word(mcr_ff, 32'h0, "mcr after refused write");
    sys(1'b1, `SDC_SYS_MCR, 32'hFFFFFFFF, 2'h0, 1'b1, 32'h0);
    sys(1'b0, `SDC_SYS_MCR, 32'h0, 2'h0, 1'b1, 32'hE005002F);
    chk_mode(mode, sdc_pkg::SDC_MODE_PAGED);
    sys(1'b1, `SDC_SYS_MCR, 32'h80000000, 2'h0, 1'b0, 32'h0);
    sys(1'b1, `SDC_SYS_MCR, 32'h40000001, 2'h0, 1'b0, 32'h0);
    chk_word(mcr_ff, 32'hE005002F, "mcr kept");
    sys(1'b1, `SDC_SYS_RSVD, 32'h1, 2'h0, 1'b0, 32'h0);
    sys(1'b1, `SDC_SYS_PAGE_BASE, 32'h12345000, 2'h0, 1'b1, 32'h0);
    chk_word(page_base_ff, 32'h12345000, "page_base");
    sys(1'b1, `SDC_SYS_FAULT_ADDR, 32'hA5A5A5A5, 2'h0, 1'b1, 32'h0);
    sys(1'b0, `SDC_SYS_FAULT_ADDR, 32'h0, 2'h0, 1'b1, 32'hA5A5A5A5);
    sys(1'b0, `SDC_SYS_FAULT_ADDR, 32'h0, 2'h1, 1'b0, 32'h0);
    sys(1'b1, `SDC_SYS_GTB_BASE, 32'h00C0FFE0, 2'h0, 1'b1, 32'h0);
    sys(1'b0, `SDC_SYS_GTB_BASE, 32'h0, 2'h0, 1'b1, 32'h00C0FFE0);
    sys(1'b0, `SDC_SYS_ITB_LIMIT, 32'h0, 2'h0, 1'b1, 32'h0000FFFF);
    sys(1'b1, `SDC_SYS_TASK_SEL, 32'hABCD1234, 2'h0, 1'b1, 32'h0);
    sys(1'b0, `SDC_SYS_TASK_SEL, 32'h0, 2'h0, 1'b1, 32'h00001234);
    sys(1'b1, `SDC_SYS_LOCAL_SEL, 32'h00000058, 2'h0, 1'b1, 32'h0);
    sys(1'b0, `SDC_SYS_LOCAL_SEL, 32'h0, 2'h0, 1'b1, 32'h00000058);
    sys(1'b0, `SDC_SYS_GTB_LIMIT, 32'h0, 2'h0, 1'b1, 32'h0000FFFF);
    sys(1'b1, `SDC_SYS_ITB_BASE, 32'h00AB0000, 2'h0, 1'b1, 32'h0);
    sys(1'b0, `SDC_SYS_ITB_BASE, 32'h0, 2'h0, 1'b1, 32'h00AB0000);
    sys(1'b0, 4'hA, 32'h0, 2'h0, 1'b0, 32'h0);
    sys(1'b1, `SDC_SYS_MCR, 32'h00000001, 2'h0, 1'b1, 32'h0);
    chk_mode(mode, sdc_pkg::SDC_MODE_PROT);
  endtask

  task automatic t_prot_loads();
    ld(`SDC_SEG_EXTRA, 16'h0008);
    mref(`SDC_SEG_EXTRA, 32'h00000FFF, 2'h0, sdc_pkg::SDC_ACC_WRITE, 1'b1,
         32'h00100FFF);
    // first byte itself past the limit
    mref(`SDC_SEG_EXTRA, 32'h00001000, 2'h0, sdc_pkg::SDC_ACC_READ, 1'b0,
         32'h0);
    mref(`SDC_SEG_EXTRA, 32'h00000FFD, 2'h3, sdc_pkg::SDC_ACC_READ, 1'b0,
         32'h0);
    mref(`SDC_SEG_EXTRA, 32'h0, 2'h0, sdc_pkg::SDC_ACC_EXEC, 1'b0,
         32'h0);
    ld(`SDC_SEG_FOURTH, 16'h0010);
    mref(`SDC_SEG_FOURTH, 32'h00000004, 2'h0, sdc_pkg::SDC_ACC_EXEC, 1'b1,
         32'h00200004);
    mref(`SDC_SEG_FOURTH, 32'h00000008, 2'h3, sdc_pkg::SDC_ACC_WRITE, 1'b0,
         32'h0);
    chk_word(lin_addr_ff, 32'h00200004, "blocked ref kept address");
    ld(`SDC_SEG_FIFTH, 16'h0018);
    mref(`SDC_SEG_FIFTH, 32'h0, 2'h0, sdc_pkg::SDC_ACC_NONE, 1'b0,
         32'h0);
  endtask

  // ------------------------------------------------------------
  // main sequence: reset for 8 cycles, then the scenarios
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset_real();
    t_sys_regs();
    t_prot_loads();
    results();
  end
endmodule

`default_nettype wire
